//--- rtl/prs_top.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] low impedance press is a timed manual reset
// [R2] press under four seconds gives soft reset
// [R3] soft reset: reset low until release plus timeout
// [R4] soft reset flag set, cleared by reading
// [R5] press over four seconds gives power cycle
// [R6] power cycle turns regulators off then on
// [R7] power cycle flag set, cleared by reading
// [R8] button state pin low while button pressed
// [R9] host pulses watchdog soft reset enable later; the code only stores CTRL bit 0 and nothing acts on it
// [R10] power up in stages zero to three
// [R11] power down in stages one to three
// [R12] sleep keeps regulators 1,3,6,9,13 on
// [R13] host holds power before release, else shutdown
// [R14] startup holds host reset through timeout
// [R15] timeout and clock are parameters; the clock rate CLK_HZ is a localparam in prs_pkg, not a module parameter
module prs_top
   import prs_pkg::*;
#(
   parameter int unsigned LONG_PRESS_CYCLES = LONG_PRESS_CYC,
   parameter int unsigned RST_TIMEOUT_CYCLES = RST_TIMEOUT_CYC,
   parameter int unsigned STAGE_CYCLES = STAGE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic button_in_n,
   input wire logic button_lowz_in_n,
   input wire logic power_hold_in,
   input wire logic power_enable_in,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic host_reset_out_n,
   output logic host_reset_oe,
   output logic button_state_out_n,
   output logic button_state_oe,
   output logic [NREG-1:0] reg_en
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      prs_mode_e mode;
      logic [31:0] cnt;
      logic seq_ok;
      logic up_req;
      logic down_req;
      logic mr_prev;
      logic press_prev;
      logic soft_flag;
      logic pc_flag;
      logic [NIRQ-1:0] irq_stat;
      logic [NIRQ-1:0] irq_mask;
      logic [1:0] ctrl;
      logic [31:0] rdata;
      logic irq;
      logic rst_oe;
      logic btn_oe;
      logic [NREG-1:0] reg_en;
   } prs_top_s;

   prs_top_s q, d;
   logic [3:0] pins;
   logic pressed;
   logic mr;
   logic rd_flags;
   logic timeout;

   prs_seq_if sq ();

   // [R15] timing parameters checked
   if (LONG_PRESS_CYCLES < 2 || RST_TIMEOUT_CYCLES < 1) begin : g_chk
      $error("press and timeout lengths too short");
   end

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
      return a == off;
   endfunction

   // ****************************************
   // pin inputs and sequencer
   // ****************************************
   prs_sync #(
      .W(4),
      .RST_VAL(RST_PINS)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din({power_enable_in, power_hold_in, button_lowz_in_n, button_in_n}),
      .dout(pins)
   );

   prs_seq #(
      .STAGE_CYCLES(STAGE_CYCLES)
   ) u_seq (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .sq(sq.seq)
   );

   assign sq.cmd_up = q.up_req;
   assign sq.cmd_down = q.down_req;

   // [R1] low impedance press detect
   assign mr = !pins[1];
   assign pressed = !pins[0] || !pins[1];
   assign rd_flags = reg_rd && hit(reg_addr, ADDR_FLAGS);
   assign timeout = (q.cnt == 32'(RST_TIMEOUT_CYCLES - 1));

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic soft_set;
      logic pc_set;
      logic [NIRQ-1:0] ev;
      logic sleep;
      soft_set = 1'b0;
      pc_set = 1'b0;
      ev = '0;
      sleep = 1'b0;
      d = q;
      d.up_req = 1'b0;
      d.down_req = 1'b0;
      d.mr_prev = mr;
      d.press_prev = pressed;
      if (sq.done) begin
         d.seq_ok = 1'b1;
      end
      case (q.mode)
         PRS_OFF: begin
            d.rst_oe = 1'b1;
            if (pressed) begin
               d.mode = PRS_BOOT;
               d.up_req = 1'b1;
               d.seq_ok = 1'b0;
               d.cnt = '0;
            end
         end
         PRS_BOOT: begin
            // [R13] no hold at release
            if (!pressed && !pins[2]) begin
               d.mode = PRS_DOWN;
               d.down_req = 1'b1;
               d.seq_ok = 1'b0;
            end else if (q.seq_ok) begin
               // [R14] startup reset timeout
               if (timeout) begin
                  d.rst_oe = 1'b0;
                  d.mode = PRS_ON;
               end else begin
                  d.cnt = q.cnt + 32'h1;
               end
            end
         end
         PRS_ON: begin
            if (!pressed && !pins[2]) begin
               d.mode = PRS_DOWN;
               d.down_req = 1'b1;
               d.rst_oe = 1'b1;
               d.seq_ok = 1'b0;
            end else if (mr && !q.mr_prev) begin
               // [R3] reset asserted at once
               d.rst_oe = 1'b1;
               d.mode = PRS_PRESS;
               d.cnt = '0;
            end
         end
         PRS_PRESS: begin
            if (q.cnt == 32'(LONG_PRESS_CYCLES - 1)) begin
               // [R5] long press power cycle
               d.mode = PRS_PC_DOWN;
               d.down_req = 1'b1;
               d.seq_ok = 1'b0;
            end else if (!pressed) begin
               // [R2] short press soft reset
               d.mode = PRS_SRST;
               d.cnt = '0;
            end else begin
               d.cnt = q.cnt + 32'h1;
            end
         end
         PRS_SRST: begin
            if (pressed) begin
               d.cnt = '0;
            end else if (timeout) begin
               // [R3] release after timeout
               d.rst_oe = 1'b0;
               d.mode = PRS_ON;
               soft_set = 1'b1;
            end else begin
               d.cnt = q.cnt + 32'h1;
            end
         end
         PRS_PC_DOWN: begin
            // [R6] off then back on
            if (q.seq_ok) begin
               d.mode = PRS_PC_UP;
               d.up_req = 1'b1;
               d.seq_ok = 1'b0;
               d.cnt = '0;
            end
         end
         PRS_PC_UP: begin
            if (q.seq_ok) begin
               if (timeout) begin
                  d.rst_oe = 1'b0;
                  d.mode = PRS_ON;
                  pc_set = 1'b1;
               end else begin
                  d.cnt = q.cnt + 32'h1;
               end
            end
         end
         PRS_DOWN: begin
            // a late done of a cut power up must not end the shutdown
            if (q.seq_ok && !sq.busy) begin
               d.mode = PRS_OFF;
            end
         end
         default: begin
            d.mode = PRS_OFF;
         end
      endcase

      // [R4] soft flag read clear
      d.soft_flag = soft_set || (q.soft_flag && !rd_flags);
      // [R7] cycle flag read clear
      d.pc_flag = pc_set || (q.pc_flag && !rd_flags);

      ev[FLAG_SOFT_BIT] = soft_set;
      ev[FLAG_PCYC_BIT] = pc_set;
      ev[IRQ_PRESS_BIT] = pressed && !q.press_prev;
      d.irq_stat = ev | q.irq_stat;
      if (reg_wr && hit(reg_addr, ADDR_IRQ_STATUS)) begin
         d.irq_stat = ev | (q.irq_stat & ~reg_wdata[NIRQ-1:0]);
      end
      if (reg_wr && hit(reg_addr, ADDR_IRQ_MASK)) begin
         d.irq_mask = reg_wdata[NIRQ-1:0];
      end
      if (reg_wr && hit(reg_addr, ADDR_CTRL)) begin
         d.ctrl = reg_wdata[1:0];
      end
      d.irq = |(q.irq_stat & q.irq_mask);

      d.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_FLAGS: begin
               d.rdata[FLAG_SOFT_BIT] = q.soft_flag;
               d.rdata[FLAG_PCYC_BIT] = q.pc_flag;
            end
            ADDR_IRQ_STATUS: begin
               d.rdata[NIRQ-1:0] = q.irq_stat;
            end
            ADDR_IRQ_MASK: begin
               d.rdata[NIRQ-1:0] = q.irq_mask;
            end
            ADDR_CTRL: begin
               d.rdata[1:0] = q.ctrl;
            end
            ADDR_STATE: begin
               d.rdata[NREG-1:0] = q.reg_en;
               d.rdata[STATE_BTN_BIT] = pressed;
               d.rdata[STATE_RST_BIT] = q.rst_oe;
               d.rdata[STATE_MODE_LSB +: 3] = q.mode;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end

      // [R8] button state mirror
      d.btn_oe = pressed;
      // [R12] sleep regulator mask
      sleep = (q.mode == PRS_ON) && (q.ctrl[CTRL_SLEEP_BIT] || !pins[3]);
      d.reg_en = sleep ? (sq.en & SLEEP_ON_MASK) : sq.en;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{mode: PRS_OFF, cnt: 32'h0, seq_ok: 1'b0, up_req: 1'b0, down_req: 1'b0,
                mr_prev: 1'b0, press_prev: 1'b0, soft_flag: 1'b0, pc_flag: 1'b0,
                irq_stat: '0, irq_mask: RST_IRQ_MASK, ctrl: RST_CTRL, rdata: 32'h0,
                irq: 1'b0, rst_oe: 1'b1, btn_oe: 1'b0, reg_en: '0};
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = q.rdata;
   assign irq = q.irq;
   assign host_reset_out_n = 1'b0;
   assign host_reset_oe = q.rst_oe;
   assign button_state_out_n = 1'b0;
   assign button_state_oe = q.btn_oe;
   assign reg_en = q.reg_en;
endmodule
`default_nettype wire

//--- include/prs_pkg.sv
`default_nettype none
package prs_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned LONG_PRESS_S = 4;
   localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
   localparam int unsigned RST_TIMEOUT_MS = 20;
   localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned STAGE_US = 1000;
   localparam int unsigned STAGE_CYC = STAGE_US * (CLK_HZ / 1_000_000);

   // ****************************************
   // regulators and stages
   // ****************************************
   localparam int NREG = 13;
   // index 0 is regulator 1, index 12 is regulator 13
   localparam logic [NREG-1:0][1:0] UP_STAGE = {2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3,
                                                2'h1, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3};
   localparam logic [NREG-1:0][1:0] DOWN_STAGE = {2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1,
                                                  2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
   localparam logic [NREG-1:0] SLEEP_ON_MASK = 13'h1125;
   localparam logic [1:0] LAST_STAGE = 2'h3;
   localparam logic [1:0] FIRST_DOWN_STAGE = 2'h1;

   // ****************************************
   // register map
   // ****************************************
   localparam int AW = 8;
   localparam logic [AW-1:0] ADDR_FLAGS = 8'h00;
   localparam logic [AW-1:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [AW-1:0] ADDR_CTRL = 8'h0C;
   localparam logic [AW-1:0] ADDR_STATE = 8'h10;
   localparam int FLAG_SOFT_BIT = 0;
   localparam int FLAG_PCYC_BIT = 1;
   localparam int IRQ_PRESS_BIT = 2;
   localparam int NIRQ = 3;
   localparam int CTRL_WD_SOFT_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int STATE_BTN_BIT = 16;
   localparam int STATE_RST_BIT = 17;
   localparam int STATE_MODE_LSB = 20;
   localparam logic [NIRQ-1:0] RST_IRQ_MASK = 3'h0;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [3:0] RST_PINS = 4'h3;

   // ****************************************
   // state encodings
   // ****************************************
   typedef enum logic [2:0] {
      PRS_OFF = 3'b000,
      PRS_BOOT = 3'b001,
      PRS_ON = 3'b010,
      PRS_PRESS = 3'b011,
      PRS_SRST = 3'b100,
      PRS_PC_DOWN = 3'b101,
      PRS_PC_UP = 3'b110,
      PRS_DOWN = 3'b111
   } prs_mode_e;

   typedef enum logic [1:0] {
      PRS_SQ_IDLE = 2'b00,
      PRS_SQ_UP = 2'b01,
      PRS_SQ_DOWN = 2'b10
   } prs_seq_e;
endpackage
`default_nettype wire

//--- include/prs_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prs_seq_if;
   logic cmd_up;
   logic cmd_down;
   logic done;
   logic busy;
   logic [12:0] en;
   modport ctl (output cmd_up, output cmd_down, input done, input busy, input en);
   modport seq (input cmd_up, input cmd_down, output done, output busy, output en);
endinterface
`default_nettype wire

//--- rtl/prs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module prs_sync
   import prs_pkg::*;
#(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } prs_sync_s;

   prs_sync_s q, d;

   // a bit moves only once the second and third stage agree
   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.o = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.o);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign dout = q.o;
endmodule
`default_nettype wire

//--- rtl/prs_seq.sv
`timescale 1ns/1ps
`default_nettype none
module prs_seq
   import prs_pkg::*;
#(
   parameter int unsigned STAGE_CYCLES = STAGE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   prs_seq_if.seq sq
);
   typedef struct packed {
      prs_seq_e mode;
      logic [1:0] stage;
      logic [31:0] cnt;
      logic [NREG-1:0] en;
      logic done;
   } prs_seq_s;

   prs_seq_s q, d;

   if (STAGE_CYCLES < 1) begin : g_chk
      $error("stage length must be at least one cycle");
   end

   function automatic logic [NREG-1:0] stage_sel(input logic [NREG-1:0][1:0] tbl, input logic [1:0] s);
      logic [NREG-1:0] m;
      m = '0;
      for (int i = 0; i < NREG; i++) begin
         m[i] = (tbl[i] == s);
      end
      return m;
   endfunction

   always_comb begin
      d = q;
      d.done = 1'b0;
      case (q.mode)
         PRS_SQ_IDLE: begin
            if (sq.cmd_up) begin
               d.mode = PRS_SQ_UP;
               d.stage = 2'h0;
               d.cnt = '0;
            end else if (sq.cmd_down) begin
               d.mode = PRS_SQ_DOWN;
               d.stage = FIRST_DOWN_STAGE;
               d.cnt = '0;
            end
         end
         PRS_SQ_UP, PRS_SQ_DOWN: begin
            if (q.cnt == 32'h0) begin
               // [R10] stage wise enable
               if (q.mode == PRS_SQ_UP) begin
                  d.en = q.en | stage_sel(UP_STAGE, q.stage);
               end else begin
                  // [R11] stage wise disable
                  d.en = q.en & ~stage_sel(DOWN_STAGE, q.stage);
               end
            end
            if (q.cnt == 32'(STAGE_CYCLES - 1)) begin
               d.cnt = '0;
               if (q.stage == LAST_STAGE) begin
                  d.mode = PRS_SQ_IDLE;
                  d.done = 1'b1;
               end else begin
                  d.stage = q.stage + 2'h1;
               end
            end else begin
               d.cnt = q.cnt + 32'h1;
            end
         end
         default: begin
            d.mode = PRS_SQ_IDLE;
         end
      endcase
      // a shutdown request cuts short a power up still in flight
      if (sq.cmd_down && q.mode == PRS_SQ_UP) begin
         d.mode = PRS_SQ_DOWN;
         d.stage = FIRST_DOWN_STAGE;
         d.cnt = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{mode: PRS_SQ_IDLE, stage: 2'h0, cnt: 32'h0, en: '0, done: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sq.en = q.en;
   assign sq.done = q.done;
   assign sq.busy = (q.mode != PRS_SQ_IDLE);
endmodule
`default_nettype wire

//--- verif/prs_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module prs_top_sva
   import prs_pkg::*;
#(
   parameter int unsigned RST_TIMEOUT_CYCLES = 10
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic button_in_n,
   input wire logic button_lowz_in_n,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic irq,
   input wire logic host_reset_oe,
   input wire logic button_state_oe,
   input wire logic [NREG-1:0] reg_en
);
   // ****
   // cycles since reset release and since button release
   // ****
   logic [15:0] up_q;
   logic [15:0] rel_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 16'h0;
         rel_q <= 16'h0;
      end else begin
         up_q <= (up_q == 16'hFFFF) ? up_q : up_q + 16'h1;
         rel_q <= !button_lowz_in_n ? 16'h0 : (rel_q == 16'hFFFF) ? rel_q : rel_q + 16'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_btn_mirror_on: assert property ($fell(button_in_n) |-> ##[2:6] button_state_oe)
      else $error("button state pin not driven after press");
   a_btn_idle_off: assert property (button_in_n [*8] |-> !button_state_oe)
      else $error("button state pin driven while released");
   a_rst_on_press: assert property ($fell(button_lowz_in_n) && !host_reset_oe |-> ##[2:8] host_reset_oe)
      else $error("host reset not asserted on manual reset");
   a_rst_held_press: assert property (!button_lowz_in_n && host_reset_oe |=> host_reset_oe)
      else $error("host reset released while button held");
   a_rst_after_timeout: assert property ($fell(host_reset_oe) |-> rel_q >= RST_TIMEOUT_CYCLES)
      else $error("host reset released before timeout");
   a_startup_hold: assert property (up_q < RST_TIMEOUT_CYCLES |-> host_reset_oe)
      else $error("host reset released too early at startup");
   a_up_stage_early: assert property ($rose(reg_en[5]) |-> $past(reg_en[12]))
      else $error("regulator 6 up before regulator 13");
   a_up_stage_late: assert property ($rose(reg_en[0]) |-> $past(reg_en[1] && reg_en[3] && reg_en[7]))
      else $error("stage 3 regulator up before stage 2");
   a_down_stage_last: assert property ($fell(reg_en[5]) |-> $past(reg_en[1:0] == 2'h0))
      else $error("regulator 6 down before earlier stages");
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read cycle");
   c_soft_release: cover property ($fell(host_reset_oe));
   c_sleep_mask: cover property (reg_en == SLEEP_ON_MASK);
   c_irq_raised: cover property ($rose(irq));
endmodule
bind prs_top prs_top_sva #(.RST_TIMEOUT_CYCLES(RST_TIMEOUT_CYCLES)) u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
   .button_in_n(button_in_n), .button_lowz_in_n(button_lowz_in_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq(irq), .host_reset_oe(host_reset_oe), .button_state_oe(button_state_oe), .reg_en(reg_en));
`default_nettype wire

//--- verif/prs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic press,
   input wire logic lowz,
   input wire logic hold_en,
   input wire logic sleep_req,
   input wire logic host_reset_oe,
   output logic button_in_n,
   output logic button_lowz_in_n,
   output logic power_hold_in,
   output logic power_enable_in
);
   assign button_in_n = !(press || lowz);
   assign button_lowz_in_n = !lowz;
   assign power_enable_in = !sleep_req;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         power_hold_in <= 1'h0;
      end else begin
         power_hold_in <= hold_en && (power_hold_in || !host_reset_oe);
      end
   end
endmodule
`default_nettype wire

//--- verif/prs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module prs_top_tb
   import prs_pkg::*;
;
   logic clk_sys, rst_n, press, lowz, hold_en, sleep_req, seen_off, watch_off;
   logic button_in_n, button_lowz_in_n, power_hold_in, power_enable_in;
   logic reg_wr, reg_rd, irq, host_reset_out_n, host_reset_oe, button_state_out_n, button_state_oe;
   logic [AW-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_q;
   logic [NREG-1:0] reg_en;
   int mismatches, num_checks, exp_flags, exp_mask, len;
   prs_top #(.LONG_PRESS_CYCLES(50), .RST_TIMEOUT_CYCLES(10), .STAGE_CYCLES(4)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .button_in_n(button_in_n), .button_lowz_in_n(button_lowz_in_n),
      .power_hold_in(power_hold_in), .power_enable_in(power_enable_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .host_reset_out_n(host_reset_out_n), .host_reset_oe(host_reset_oe), .button_state_out_n(button_state_out_n),
      .button_state_oe(button_state_oe), .reg_en(reg_en));
   prs_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .press(press), .lowz(lowz), .hold_en(hold_en),
      .sleep_req(sleep_req), .host_reset_oe(host_reset_oe), .button_in_n(button_in_n),
      .button_lowz_in_n(button_lowz_in_n), .power_hold_in(power_hold_in), .power_enable_in(power_enable_in));
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      seen_off <= watch_off && (seen_off || reg_en === 13'h1000);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 rd_q = reg_rdata;
      chk(rd_q, exp);
   endtask
   task automatic wait_oe(input logic v, input int lim);
      int n;
      n = 0;
      while (n < lim && host_reset_oe !== v) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= lim) begin
         chk(32'h1, 32'h0);
         close_out();
      end
   endtask
   initial begin
      rst_n = 1'h0;
      {press, lowz, hold_en, sleep_req, reg_wr, reg_rd, watch_off} = 7'h0;
      reg_addr = '0;
      reg_wdata = 32'h0;
      mismatches = 0;
      num_checks = 0;
      void'($urandom(32'h619B223B));
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(negedge clk_sys);
      chk(32'(reg_en), 32'h0);
      chk(32'(host_reset_oe), 32'h1);
      chk(32'({host_reset_out_n, button_state_out_n}), 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(8'hFC, 32'h0);
      exp_mask = $urandom;
      wr(ADDR_IRQ_MASK, exp_mask);
      exp_mask = exp_mask & 7;
      rd(ADDR_IRQ_MASK, exp_mask);
      @(posedge clk_sys);
      hold_en <= 1'h1;
      press <= 1'h1;
      wait_oe(1'h0, 200);
      chk(32'(button_state_oe), 32'h1);
      repeat (8) @(posedge clk_sys);
      press <= 1'h0;
      repeat (10) @(negedge clk_sys);
      chk(32'(reg_en), 32'h1FFF);
      chk(32'(host_reset_oe), 32'h0);
      chk(32'(button_state_oe), 32'h0);
      rd(ADDR_STATE, (32'(PRS_ON) << STATE_MODE_LSB) | 32'h1FFF);
      wr(ADDR_IRQ_STATUS, 32'h7);
      len = 10 + $urandom % 20;
      @(posedge clk_sys);
      lowz <= 1'h1;
      repeat (len) @(posedge clk_sys);
      lowz <= 1'h0;
      repeat (5) @(negedge clk_sys);
      chk(32'(host_reset_oe), 32'h1);
      wait_oe(1'h0, 40);
      exp_flags = 1 << FLAG_SOFT_BIT;
      rd(ADDR_FLAGS, exp_flags);
      rd(ADDR_FLAGS, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h5);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_IRQ_MASK, i);
         repeat (3) @(negedge clk_sys);
         chk(32'(irq), 32'((5 & i) != 0));
      end
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'h5);
      repeat (3) @(negedge clk_sys);
      chk(32'(irq), 32'h0);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_CTRL, 32'h1);
      wr(ADDR_CTRL, 32'h0);
      watch_off <= 1'h1;
      @(posedge clk_sys);
      lowz <= 1'h1;
      repeat (60) @(posedge clk_sys);
      lowz <= 1'h0;
      wait_oe(1'h0, 100);
      @(negedge clk_sys);
      chk(32'(seen_off), 32'h1);
      chk(32'(reg_en), 32'h1FFF);
      rd(ADDR_FLAGS, 32'h1 << FLAG_PCYC_BIT);
      rd(ADDR_FLAGS, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h6);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) begin
            wr(ADDR_CTRL, 32'h2);
         end else begin
            @(posedge clk_sys);
            sleep_req <= 1'h1;
         end
         repeat (30) @(negedge clk_sys);
         chk(32'(reg_en), 32'(SLEEP_ON_MASK));
         @(posedge clk_sys);
         sleep_req <= 1'h0;
         wr(ADDR_CTRL, 32'h0);
         repeat (30) @(negedge clk_sys);
         chk(32'(reg_en), 32'h1FFF);
      end
      @(posedge clk_sys);
      hold_en <= 1'h0;
      repeat (40) @(negedge clk_sys);
      chk(32'(reg_en), 32'h1000);
      chk(32'(host_reset_oe), 32'h1);
      // press released during boot without power hold: back to off
      @(posedge clk_sys);
      press <= 1'h1;
      repeat (8) @(posedge clk_sys);
      press <= 1'h0;
      repeat (40) @(negedge clk_sys);
      chk(32'(reg_en), 32'h1000);
      rd(ADDR_STATE, (32'h1 << STATE_RST_BIT) | 32'h1000);
      close_out();
   end
endmodule
`default_nettype wire
